// >>> core/lcdi2c_map.vh
// Constants for the LCD driver serial write slave
`ifndef LCDI2C_MAP_VH
`define LCDI2C_MAP_VH
`define LCDI2C_ADDR_UPPER 6'h1c
`define LCDI2C_CTRL_CONT_BIT 7
`define LCDI2C_CTRL_DEST_BIT 6
`define LCDI2C_DEVSEL_UPPER 5'h1c
`define LCDI2C_PTR_MAX 7'h3b
`define LCDI2C_PTR_RST 7'h00
`define LCDI2C_SUB_RST 3'h0
`define LCDI2C_FILT_CYCLES 3'h4
`define LCDI2C_BITS_PER_BYTE 4'h8
`endif

// >>> core/lcdi2c_filter.v
// Input synchroniser and glitch filter for one serial line
`timescale 1ns/1ps
module lcdi2c_filter (
  input wire i_core_clk,
  input wire i_reset_n,
  input wire i_en,
  input wire i_line,
  output reg o_line
);
`include "lcdi2c_map.vh"
  reg sync1_q;
  reg sync2_q;
  reg [2:0] cnt_q;
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      cnt_q <= 3'h0;
      o_line <= 1'b1;
    end else if (i_en) begin
      sync1_q <= i_line;
      sync2_q <= sync1_q;
      // Accept a new level only after it stays stable [R24]
      if (sync2_q == o_line) begin
        cnt_q <= 3'h0;
      end else if (cnt_q == `LCDI2C_FILT_CYCLES - 3'h1) begin
        o_line <= sync2_q;
        cnt_q <= 3'h0;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end
endmodule // lcdi2c_filter

// >>> core/lcdi2c_slave.v
// Write-only serial slave receiver for a segment LCD driver
//
// Overview of operation
// [R1] Idle bus has both lines high
// [R2] Master starts only on idle bus
// [R3] Sample data on clock rising edge
// [R4] Data fall with clock high is START
// [R5] Data rise with clock high is STOP
// [R6] Eight bits plus ack, unlimited bytes
// [R7] Acknowledge every byte when addressed; display bytes are acked only on subaddress match
// [R8] Hold data low through ack high
// [R9] Receive only; drive nothing but ack
// [R10] Answer only addresses 0111000 and 0111001
// [R11] Address bit 1 equals strap pin
// [R12] Read requests are never acknowledged
// [R13] Unmatched strap ignores transfer until START
// [R14] Control bit 7 flags more control bytes
// [R15] Control bit 6 picks command or display
// [R16] Control and command bytes always acknowledged
// [R17] Display byte written, pointer and counter advance
// [R18] Display ack only on subaddress match
// [R19] Selection uses address, subaddress, pins
// [R20] Master ends with STOP or restart
// [R21] Device-select loads subaddress counter
// [R22] Bit 7 clear loads data pointer
// [R23] Last control byte fixes later routing
// [R24] Lines synchronised and glitch filtered
`timescale 1ns/1ps
module lcdi2c_slave (
  input wire i_core_clk,
  input wire i_reset_n,
  input wire i_clk_en,
  input wire i_scl,
  input wire i_sda,
  input wire i_address_bit_strap,
  input wire i_hw_subaddr_pin_0,
  input wire i_hw_subaddr_pin_1,
  input wire i_hw_subaddr_pin_2,
  output reg o_sda_out,
  output reg o_sda_oe,
  output reg o_busy,
  output reg o_cmd_valid,
  output reg [7:0] o_cmd_byte,
  output reg o_disp_valid,
  output reg [7:0] o_disp_byte,
  output reg [6:0] o_disp_ptr,
  output reg [2:0] o_disp_sub,
  output reg [6:0] o_data_ptr,
  output reg [2:0] o_subaddr
);
`include "lcdi2c_map.vh"
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CTRL = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_IGNORE = 3'h4;

  genvar g;
  wire [1:0] line_in;
  wire [1:0] line_f;
  wire scl_f;
  wire sda_f;
  reg scl_q;
  reg sda_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] shift_q;
  reg [7:0] shift_d;
  reg [3:0] bit_q;
  reg [3:0] bit_d;
  reg in_ack_q;
  reg in_ack_d;
  reg ack_hi_q;
  reg ack_hi_d;
  reg ack_q;
  reg ack_d;
  reg cont_q;
  reg cont_d;
  reg dest_q;
  reg dest_d;
  reg oe_d;
  reg busy_d;
  reg cmd_valid_d;
  reg [7:0] cmd_byte_d;
  reg disp_valid_d;
  reg [7:0] disp_byte_d;
  reg [6:0] disp_ptr_d;
  reg [2:0] disp_sub_d;
  reg [6:0] data_ptr_d;
  reg [2:0] subaddr_d;
  wire [2:0] pins;
  wire [2:0] sub_eq;
  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;
  wire active_c;
  wire byte_end_c;
  wire data_end_c;
  wire [7:0] byte_c;
  wire addr_ok;
  wire sub_ok;
  wire devsel_c;
  wire ptr_last_c;

  // Clock and data lines, one filter each [R24]
  assign line_in = {i_sda, i_scl};
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_filt
      lcdi2c_filter u_filt (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_en(i_clk_en),
        .i_line(line_in[g]),
        .o_line(line_f[g])
      );
    end
  endgenerate
  assign scl_f = line_f[0];
  assign sda_f = line_f[1];

  assign pins = {i_hw_subaddr_pin_2, i_hw_subaddr_pin_1, i_hw_subaddr_pin_0};
  // Per-bit match of counter and pins [R18] [R19]
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sub
      assign sub_eq[g] = ~(o_subaddr[g] ^ pins[g]);
    end
  endgenerate
  assign sub_ok = &sub_eq; // [R18] [R19]

  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;
  assign start_c = scl_f & scl_q & sda_q & ~sda_f; // [R4]
  assign stop_c = scl_f & scl_q & ~sda_q & sda_f; // [R5]
  assign active_c = (state_q != ST_IDLE) && (state_q != ST_IGNORE);
  assign byte_c = {shift_q[6:0], sda_f}; // [R3]
  assign byte_end_c = scl_rise && !in_ack_q &&
    (bit_q == `LCDI2C_BITS_PER_BYTE - 4'h1); // [R6]
  assign data_end_c = byte_end_c && (state_q == ST_DATA);
  // Fixed upper bits, strap bit and write-only direction
  assign addr_ok = (byte_c[7:2] == `LCDI2C_ADDR_UPPER) &&
    (byte_c[1] == i_address_bit_strap) && !byte_c[0]; // [R10] [R11] [R12]
  assign devsel_c = (byte_c[7:3] == `LCDI2C_DEVSEL_UPPER); // [R21]
  assign ptr_last_c = (o_data_ptr >= `LCDI2C_PTR_MAX); // [R17]

  // Frame tracking, bit count and ack timing
  always @* begin
    state_d = state_q;
    shift_d = shift_q;
    bit_d = bit_q;
    in_ack_d = in_ack_q;
    ack_hi_d = ack_hi_q;
    ack_d = ack_q;
    cont_d = cont_q;
    dest_d = dest_q;
    oe_d = o_sda_oe;
    busy_d = o_busy;
    if (start_c) begin
      // START or restart from any state [R2] [R20]
      state_d = ST_ADDR;
      bit_d = 4'h0;
      in_ack_d = 1'b0;
      ack_hi_d = 1'b0;
      ack_d = 1'b0;
      cont_d = 1'b1;
      oe_d = 1'b0;
      busy_d = 1'b1;
    end else if (stop_c) begin
      // Back to idle with both lines high [R1]
      state_d = ST_IDLE;
      in_ack_d = 1'b0;
      ack_hi_d = 1'b0;
      ack_d = 1'b0;
      oe_d = 1'b0;
      busy_d = 1'b0;
    end else if (active_c) begin
      if (scl_rise && !in_ack_q) begin
        shift_d = byte_c; // [R3]
        bit_d = bit_q + 4'h1;
        if (byte_end_c) begin // [R6]
          bit_d = 4'h0;
          in_ack_d = 1'b1;
          ack_hi_d = 1'b0;
          ack_d = 1'b0;
          case (state_q)
            ST_ADDR: begin
              if (addr_ok) begin
                ack_d = 1'b1; // [R7] [R13]
                state_d = ST_CTRL;
              end else begin
                state_d = ST_IGNORE; // [R13]
              end
            end
            ST_CTRL: begin
              ack_d = 1'b1; // [R16]
              cont_d = byte_c[`LCDI2C_CTRL_CONT_BIT]; // [R14]
              dest_d = byte_c[`LCDI2C_CTRL_DEST_BIT]; // [R15]
              state_d = ST_DATA;
            end
            ST_DATA: begin
              if (!dest_q) begin
                ack_d = 1'b1; // [R16]
              end else begin
                ack_d = sub_ok; // [R18]
              end
              // More control bytes or fixed routing [R14] [R23]
              if (cont_q) begin
                state_d = ST_CTRL;
              end
            end
            default: begin
              state_d = ST_IGNORE;
            end
          endcase
        end
      end else if (scl_rise) begin
        // Ninth clock pulse under way
        ack_hi_d = 1'b1;
      end else if (scl_fall && in_ack_q) begin
        if (!ack_hi_q) begin
          // Pull low for the whole ninth pulse [R8]
          oe_d = ack_q;
        end else begin
          // Release after the ack pulse [R8]
          oe_d = 1'b0;
          in_ack_d = 1'b0;
          ack_hi_d = 1'b0;
          ack_d = 1'b0;
        end
      end
    end
  end

  // Command and display paths, pointer advance
  always @* begin
    cmd_valid_d = 1'b0;
    cmd_byte_d = o_cmd_byte;
    disp_valid_d = 1'b0;
    disp_byte_d = o_disp_byte;
    disp_ptr_d = o_disp_ptr;
    disp_sub_d = o_disp_sub;
    data_ptr_d = o_data_ptr;
    subaddr_d = o_subaddr;
    if (!start_c && !stop_c && data_end_c) begin
      if (!dest_q) begin
        cmd_valid_d = 1'b1;
        cmd_byte_d = byte_c;
        if (!byte_c[7]) begin
          data_ptr_d = byte_c[6:0]; // [R22]
        end else if (devsel_c) begin
          subaddr_d = byte_c[2:0]; // [R21]
        end
      end else begin
        disp_valid_d = 1'b1; // [R17]
        disp_byte_d = byte_c;
        disp_ptr_d = o_data_ptr;
        disp_sub_d = o_subaddr;
        // Pointer wraps and bumps subaddress [R17]
        if (ptr_last_c) begin
          data_ptr_d = `LCDI2C_PTR_RST;
          subaddr_d = o_subaddr + 3'h1;
        end else begin
          data_ptr_d = o_data_ptr + 7'h01;
        end
      end
    end
  end

  // Edge history of the filtered lines
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (i_clk_en) begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // Frame state registers
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      bit_q <= 4'h0;
      in_ack_q <= 1'b0;
      ack_hi_q <= 1'b0;
      ack_q <= 1'b0;
      cont_q <= 1'b1;
      dest_q <= 1'b0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      shift_q <= shift_d;
      bit_q <= bit_d;
      in_ack_q <= in_ack_d;
      ack_hi_q <= ack_hi_d;
      ack_q <= ack_d;
      cont_q <= cont_d;
      dest_q <= dest_d;
    end
  end

  // Line drive and frame outputs
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
      o_busy <= 1'b0;
    end else if (i_clk_en) begin
      o_sda_out <= 1'b0; // [R9]
      o_sda_oe <= oe_d; // [R8]
      o_busy <= busy_d;
    end
  end

  // Command and display outputs
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cmd_valid <= 1'b0;
      o_cmd_byte <= 8'h00;
      o_disp_valid <= 1'b0;
      o_disp_byte <= 8'h00;
      o_disp_ptr <= `LCDI2C_PTR_RST;
      o_disp_sub <= `LCDI2C_SUB_RST;
    end else if (i_clk_en) begin
      o_cmd_valid <= cmd_valid_d;
      o_cmd_byte <= cmd_byte_d;
      o_disp_valid <= disp_valid_d;
      o_disp_byte <= disp_byte_d;
      o_disp_ptr <= disp_ptr_d;
      o_disp_sub <= disp_sub_d;
    end
  end

  // Data pointer and subaddress counter
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_data_ptr <= `LCDI2C_PTR_RST;
      o_subaddr <= `LCDI2C_SUB_RST;
    end else if (i_clk_en) begin
      o_data_ptr <= data_ptr_d;
      o_subaddr <= subaddr_d;
    end
  end
endmodule // lcdi2c_slave

// >>> verif/lcdi2c_master.sv
// Bus master model for the serial lines
`timescale 1ns/1ps
module lcdi2c_master (
  input wire i_core_clk,
  input wire i_line,
  output reg o_scl = 1'b1,
  output reg o_sda = 1'b1
);
  task ph;
    repeat (10) @(negedge i_core_clk);
  endtask
  task go;
    o_sda = 1'b1;
    ph;
    o_scl = 1'b1;
    ph;
    o_sda = 1'b0;
    ph;
    o_scl = 1'b0;
    ph;
  endtask
  task halt;
    o_sda = 1'b0;
    ph;
    o_scl = 1'b1;
    ph;
    o_sda = 1'b1;
    ph;
  endtask
  task wb(input [8:0] b, output ack);
    integer i;
    for (i = 8; i >= 0; i = i - 1) begin
      o_sda = b[i];
      ph;
      o_scl = 1'b1;
      ph;
      ack = !i_line;
      o_scl = 1'b0;
      ph;
    end
  endtask
endmodule // lcdi2c_master

// >>> verif/lcdi2c_slave_properties.sv
// Assertion checker on the serial slave ports
`timescale 1ns/1ps
module lcdi2c_slave_properties (
  input wire i_core_clk,
  input wire i_reset_n,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda_out,
  input wire o_sda_oe,
  input wire o_busy,
  input wire o_cmd_valid,
  input wire [7:0] o_cmd_byte,
  input wire [6:0] o_data_ptr,
  input wire [2:0] o_subaddr
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  ack_only_low_a: assert property (o_sda_oe |-> !o_sda_out)
    else $error("line driven high");
  ack_in_frame_a: assert property (o_sda_oe |-> o_busy)
    else $error("ack outside frame");
  start_seen_a: assert property ($rose(o_busy) |-> i_scl)
    else $error("bad start");
  stop_seen_a: assert property ($fell(o_busy) |-> i_scl && i_sda)
    else $error("bad stop");
  ack_stand_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
    else $error("ack too short");
  ack_edge_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("ack moved, clock high");
  sub_load_a: assert property (o_cmd_valid && o_cmd_byte[7:3] == 5'h1c
    |=> ##[0:1] o_subaddr == o_cmd_byte[2:0])
    else $error("subaddress not loaded");
  ptr_load_a: assert property (o_cmd_valid && !o_cmd_byte[7]
    |=> ##[0:1] o_data_ptr == o_cmd_byte[6:0])
    else $error("pointer not loaded");
endmodule // lcdi2c_slave_properties
bind lcdi2c_slave lcdi2c_slave_properties lcdi2c_slave_properties_inst (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_busy(o_busy), .o_cmd_valid(o_cmd_valid), .o_cmd_byte(o_cmd_byte),
  .o_data_ptr(o_data_ptr), .o_subaddr(o_subaddr));

// >>> verif/tb_lcdi2c_slave.sv
// Self-checking bench for the serial write slave
`timescale 1ns/1ps
module tb_lcdi2c_slave;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg strap = 1'b0;
  reg [2:0] pins = 3'h0;
  reg [7:0] d0;
  reg [7:0] d1;
  reg a;
  wire scl, sda, so, oe, cv, dv, bz;
  wire [7:0] cb, db;
  wire [6:0] dp, pt;
  wire [2:0] ds, sb;
  wire line = sda & ~(oe & ~so);
  integer n_mismatch = 0;
  integer tests_run = 0;
  reg [18:0] q[$];
  initial forever #5 clk = ~clk;
  lcdi2c_master lcdi2c_master_inst (.i_core_clk(clk), .i_line(line),
    .o_scl(scl), .o_sda(sda));
  lcdi2c_slave lcdi2c_slave_inst (.i_core_clk(clk), .i_reset_n(rst_n),
    .i_clk_en(1'b1), .i_scl(scl), .i_sda(line),
    .i_address_bit_strap(strap), .i_hw_subaddr_pin_0(pins[0]),
    .i_hw_subaddr_pin_1(pins[1]), .i_hw_subaddr_pin_2(pins[2]),
    .o_sda_out(so), .o_sda_oe(oe), .o_busy(bz), .o_cmd_valid(cv),
    .o_cmd_byte(cb), .o_disp_valid(dv), .o_disp_byte(db),
    .o_disp_ptr(dp), .o_disp_sub(ds), .o_data_ptr(pt), .o_subaddr(sb));
  task ck(input [31:0] nm, input [18:0] e, input [18:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value %0s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] b, input ex);
    lcdi2c_master_inst.wb({b, 1'b1}, a);
    ck("ack", {18'h0, ex}, {18'h0, a});
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(negedge clk)
    if (cv | dv)
      ck("note", q.pop_front(),
        {dv, dv ? {dp, ds} : 10'h0, dv ? db : cb});
  initial begin
    d0 = $urandom(32'h6a46);
    {strap, pins, d1} = $urandom;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    lcdi2c_master_inst.go;
    ck("busy", 19'h1, {18'h0, bz});
    wr({6'h1c, strap, 1'b0}, 1'b1);
    wr(8'h80, 1'b1);
    q.push_back({11'h0, 5'h1c, pins});
    wr({5'h1c, pins}, 1'b1);
    wr(8'h00, 1'b1);
    q.push_back(19'h3b);
    wr(8'h3b, 1'b1);
    lcdi2c_master_inst.go;
    wr({6'h1c, strap, 1'b0}, 1'b1);
    wr(8'h40, 1'b1);
    q.push_back({1'b1, 7'h3b, pins, d0});
    wr(d0, 1'b1);
    q.push_back({1'b1, 7'h00, pins + 3'h1, d1});
    wr(d1, 1'b0);
    q.push_back({1'b1, 7'h01, pins + 3'h1, d0});
    wr(d0, 1'b0);
    lcdi2c_master_inst.halt;
    ck("busy", 19'h0, {18'h0, bz});
    ck("ptr", 19'h2, {12'h0, pt});
    ck("sub", {16'h0, pins + 3'h1}, {16'h0, sb});
    lcdi2c_master_inst.go;
    wr({6'h1c, ~strap, 1'b0}, 1'b0);
    wr(8'h80, 1'b0);
    lcdi2c_master_inst.go;
    wr({6'h1c, strap, 1'b1}, 1'b0);
    lcdi2c_master_inst.halt;
    ck("left", 19'h0, q.size());
    complete_run;
  end
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
endmodule // tb_lcdi2c_slave
